// File: src/tsgn_ctrl.sv
// Task-switch gate privilege check and task nesting control, AXI4-Lite slave
// Overview of operation
// R01 - Gate privilege level is taken from the gate descriptor field before deciding.
// R02 - First gate check passes only when current level <= gate level.
// R03 - Second gate check passes only when selector requested level <= gate level.
// R04 - Gate switches never compare current level against target descriptor level.
// R05 - Failing either gate check denies entry into the target task.
// R06 - In long mode any task gate transfer raises a protection fault.
// R07 - Jump leaves nested flag and link field unchanged in both tasks.
// R08 - Call or interrupt sets new nested flag, links old selector into new task.
// R09 - Interrupt return switches only with nested flag set, target from link field.
// R10 - Interrupt return clears the outgoing task's nested flag.
// R11 - Nested flag may be set at any privilege level; no level check.
// R12 - Busy indication is bit 9 of the descriptor word at byte offset +4.
// R13 - Jump clears outgoing busy and sets incoming busy.
// R14 - Jump to an already busy task faults and does not switch.
// R15 - Call or interrupt sets incoming busy and leaves outgoing busy set.
// R16 - Call or interrupt to an already busy task faults instead of switching.
// R17 - Interrupt return clears outgoing busy, leaves incoming busy untouched.
// R18 - Failed privilege check aborts with no state change and a protection fault.
// R19 - Software, hardware interrupts and exceptions bypass gate privilege checks.
// R20 - Interrupt return makes no comparison against target descriptor level.
// R21 - Privilege comparisons are unsigned two-bit, zero most privileged.
`timescale 1ns/100ps
`include "tsgn_regs.svh"

module tsgn_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // Write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // Write response channel
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // Read data channel
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Decision outputs to the execution sequencer
  output logic                   protection_fault,
  output logic                   switch_taken
);

  tsgn_pkg::tsgn_state_t s_q;
  tsgn_pkg::tsgn_state_t s_d;

  // Decoded request fields, valid while a request word is being written
  tsgn_pkg::tsgn_kind_t kind;
  logic       via_gate;
  logic       long_mode;
  logic       nested_task_flag;
  logic [1:0] current_privilege_level;
  logic [1:0] selector_requested_privilege;
  logic [1:0] gate_privilege_level;
  logic [15:0] old_selector;
  logic       target_busy;
  logic       gate_ok;
  logic       cpl_ok;
  logic       rpl_ok;
  logic       gate_banned;
  logic       fault;
  logic       go;
  logic [31:0] res;
  logic [31:0] desc_new;

  // Merge write data through byte strobes over a base word; the write path passes zero
  function automatic logic [31:0] tsgn_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : tsgn_merge

  // Request decode and the switch decision
  always_comb begin
    kind = tsgn_pkg::tsgn_kind_t'(s_q.wdata[`TSGN_REQ_KIND_LSB +: 2]);
    via_gate = s_q.wdata[`TSGN_REQ_GATE_BIT];
    long_mode = s_q.wdata[`TSGN_REQ_LONG_BIT];
    // Flag is taken as given, whatever level set it [R11]
    nested_task_flag = s_q.wdata[`TSGN_REQ_NT_BIT];
    current_privilege_level = s_q.wdata[`TSGN_REQ_CPL_LSB +: 2];
    selector_requested_privilege = s_q.wdata[`TSGN_REQ_RPL_LSB +: 2];
    // Gate level comes from the descriptor field of the request [R01]
    gate_privilege_level = s_q.wdata[`TSGN_REQ_GDPL_LSB +: 2];
    old_selector = s_q.wdata[`TSGN_REQ_OLD_LSB +: 16];
    // Busy bit of the target descriptor's second word [R12]
    target_busy = s_q.desc[`TSGN_DESC_BUSY_BIT];
    // Unsigned 2-bit compares, zero most privileged [R21]
    // First check: current level no weaker than the gate level [R02]
    cpl_ok = (current_privilege_level <= gate_privilege_level);
    // Second check: selector's requested level no weaker than the gate [R03]
    rpl_ok = (selector_requested_privilege <= gate_privilege_level);
    // Target descriptor level plays no part in a gate switch [R04]
    // Either failure alone refuses the switch [R05]
    gate_ok = cpl_ok && rpl_ok;
    // No task gates in long mode; no privilege level can rescue them [R06]
    gate_banned = via_gate && long_mode;
    fault = 1'b0;
    go = 1'b0;
    res = 32'h0000_0000;
    desc_new = s_q.desc;
    unique case (kind)
      tsgn_pkg::TSGN_JUMP: begin
        // Gate checks only for jump and call through a gate [R19]
        fault = gate_banned || (via_gate && !gate_ok) || target_busy; // [R06] [R14] [R18]
        go = !fault;
        // Nested flag and link untouched [R07]; old busy cleared, new set [R13]
        res[`TSGN_RES_OLDBUSY] = 1'b0;
        res[`TSGN_RES_NEWBUSY] = 1'b1;
        res[`TSGN_RES_OLDNT] = nested_task_flag;
        if (go) begin
          desc_new[`TSGN_DESC_BUSY_BIT] = 1'b1; // [R13]
        end
      end
      tsgn_pkg::TSGN_CALL: begin
        fault = gate_banned || (via_gate && !gate_ok) || target_busy; // [R06] [R16] [R18]
        go = !fault;
        res[`TSGN_RES_OLDBUSY] = 1'b1; // [R15]
        res[`TSGN_RES_NEWBUSY] = 1'b1;
        res[`TSGN_RES_OLDNT] = nested_task_flag;
        res[`TSGN_RES_NEWNT] = 1'b1; // [R08]
        res[`TSGN_RES_WRLINK] = 1'b1;
        res[`TSGN_RES_LINK_LSB +: 16] = old_selector; // [R08]
        if (go) begin
          desc_new[`TSGN_DESC_BUSY_BIT] = 1'b1; // [R15]
        end
      end
      tsgn_pkg::TSGN_INTR: begin
        // Interrupts skip privilege checks, but a gate is still illegal in long mode
        fault = gate_banned || target_busy; // [R19] [R06] [R16]
        go = !fault;
        res[`TSGN_RES_OLDBUSY] = 1'b1; // [R15]
        res[`TSGN_RES_NEWBUSY] = 1'b1;
        res[`TSGN_RES_OLDNT] = nested_task_flag;
        res[`TSGN_RES_NEWNT] = 1'b1; // [R08]
        res[`TSGN_RES_WRLINK] = 1'b1;
        res[`TSGN_RES_LINK_LSB +: 16] = old_selector;
        if (go) begin
          desc_new[`TSGN_DESC_BUSY_BIT] = 1'b1;
        end
      end
      tsgn_pkg::TSGN_INTERRUPT_RETURN: begin
        // Switch only when nested; target is the link field, no level compare [R09] [R20]
        go = nested_task_flag;
        res[`TSGN_RES_OLDBUSY] = !go; // [R17]
        res[`TSGN_RES_NEWBUSY] = target_busy; // [R17]
        res[`TSGN_RES_OLDNT] = !go && nested_task_flag; // [R10]
        res[`TSGN_RES_NEWNT] = 1'b0;
      end
    endcase
    if (fault) begin
      // Abort leaves every outgoing state copy as it stood [R18]
      res = 32'h0000_0000;
      res[`TSGN_RES_OLDBUSY] = 1'b1;
      res[`TSGN_RES_OLDNT] = nested_task_flag;
      desc_new = s_q.desc;
    end
  end

  // Bus channels and register file in one next-state copy
  always_comb begin
    s_d = s_q;
    // Write address and data taken independently, in either order
    if (s_axi_awvalid && s_q.awrdy) begin
      s_d.awaddr = s_axi_awaddr[7:0];
      s_d.aw_have = 1'b1;
      s_d.awrdy = 1'b0;
    end
    if (s_axi_wvalid && s_q.wrdy) begin
      s_d.wdata = tsgn_merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
      s_d.w_have = 1'b1;
      s_d.wrdy = 1'b0;
    end
    // Both halves present: act on the write one cycle later
    if (s_q.wst == tsgn_pkg::TSGN_W_IDLE && s_q.aw_have && s_q.w_have) begin
      s_d.wst = tsgn_pkg::TSGN_W_RESP;
      s_d.bvalid = 1'b1;
      s_d.bresp = `TSGN_RESP_OKAY;
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      unique case (s_q.awaddr)
        `TSGN_OFF_REQ: begin
          s_d.done = 1'b1;
          s_d.fault = fault;
          s_d.switched = go;
          s_d.result = res;
          s_d.desc = desc_new;
        end
        `TSGN_OFF_DESC: begin
          s_d.desc = s_q.wdata;
        end
        `TSGN_OFF_STATUS: begin
          // Write one to clear the sticky done flag
          if (s_q.wdata[`TSGN_ST_DONE_BIT]) begin
            s_d.done = 1'b0;
          end
        end
        default: begin
          s_d.bresp = `TSGN_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.wst == tsgn_pkg::TSGN_W_RESP && s_axi_bready) begin
      s_d.wst = tsgn_pkg::TSGN_W_IDLE;
      s_d.bvalid = 1'b0;
      s_d.awrdy = 1'b1;
      s_d.wrdy = 1'b1;
    end
    // Read path: one outstanding read, answered the cycle after address
    if (s_axi_arvalid && s_q.arrdy) begin
      s_d.arrdy = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = `TSGN_RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        `TSGN_OFF_STATUS: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rdata[`TSGN_ST_DONE_BIT] = s_q.done;
          s_d.rdata[`TSGN_ST_FAULT_BIT] = s_q.fault;
          s_d.rdata[`TSGN_ST_SWITCH_BIT] = s_q.switched;
        end
        `TSGN_OFF_RESULT: s_d.rdata = s_q.result;
        `TSGN_OFF_DESC:   s_d.rdata = s_q.desc;
        `TSGN_OFF_REQ:    s_d.rdata = 32'h0000_0000;
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `TSGN_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arrdy = 1'b1;
    end
  end

  // Single state register; synchronous reset to constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awrdy <= 1'b1;
      s_q.wrdy <= 1'b1;
      s_q.arrdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready = s_q.wrdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arrdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign protection_fault = s_q.fault;
  assign switch_taken = s_q.switched;

endmodule : tsgn_ctrl

// File: shared/tsgn_regs.svh
// Register offsets, field positions and response codes for the task-switch gate block
`ifndef TSGN_REGS_SVH
`define TSGN_REGS_SVH
`define TSGN_OFF_REQ        8'h00
`define TSGN_OFF_STATUS     8'h04
`define TSGN_OFF_RESULT     8'h08
`define TSGN_OFF_DESC       8'h0C
`define TSGN_REQ_KIND_LSB   0
`define TSGN_REQ_GATE_BIT   3
`define TSGN_REQ_LONG_BIT   4
`define TSGN_REQ_NT_BIT     5
`define TSGN_REQ_CPL_LSB    8
`define TSGN_REQ_RPL_LSB    10
`define TSGN_REQ_GDPL_LSB   12
`define TSGN_REQ_OLD_LSB    16
`define TSGN_DESC_BUSY_BIT  9
`define TSGN_DESC_BYTE_OFF  4
`define TSGN_ST_DONE_BIT    0
`define TSGN_ST_FAULT_BIT   1
`define TSGN_ST_SWITCH_BIT  2
`define TSGN_RES_OLDBUSY    0
`define TSGN_RES_NEWBUSY    1
`define TSGN_RES_OLDNT      2
`define TSGN_RES_NEWNT      3
`define TSGN_RES_WRLINK     4
`define TSGN_RES_LINK_LSB   16
`define TSGN_RESP_OKAY      2'h0
`define TSGN_RESP_SLVERR    2'h2
`endif

// File: shared/tsgn_pkg.sv
// Types for the task-switch gate and nesting control block
package tsgn_pkg;
  typedef enum logic [1:0] {
    TSGN_JUMP,
    TSGN_CALL,
    TSGN_INTR,
    TSGN_INTERRUPT_RETURN
  } tsgn_kind_t;
  typedef enum logic [1:0] {
    TSGN_W_IDLE,
    TSGN_W_RESP
  } tsgn_wst_t;
  typedef struct packed {
    tsgn_wst_t   wst;
    logic        awrdy;
    logic        wrdy;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] desc;
    logic        done;
    logic        fault;
    logic        switched;
    logic [31:0] result;
  } tsgn_state_t;
endpackage : tsgn_pkg

// File: verif/tsgn_ctrl_sva.sv
// Handshake and decision checks on the gate block ports
`timescale 1ns/100ps
module tsgn_ctrl_sva (
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic protection_fault,
  input wire logic switch_taken
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Answer timing, and no new transfer while one is open
  a_b_delay: assert property (s_axi_awvalid && s_axi_awready |-> ##2 s_axi_bvalid)
    else $error("b late");
  a_r_delay: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("r late");
  a_aw_shut: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
  a_ar_shut: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  a_aw_reopen: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready)
    else $error("aw shut");
  a_ar_reopen: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
    else $error("ar shut");
  // Decisions move only with a write answer, never fault and switch at once
  a_out_hold: assert property (
    !$rose(s_axi_bvalid) |-> $stable({protection_fault, switch_taken})) else $error("moved");
  a_one_outcome: assert property (
    !(protection_fault && switch_taken)) else $error("both");
  c_fault: cover property ($rose(protection_fault));
  c_switch: cover property ($rose(switch_taken));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : tsgn_ctrl_sva

// File: verif/tsgn_seq_model.sv
// AXI4-Lite master standing in for the execution sequencer
`timescale 1ns/100ps
module tsgn_seq_model (
  // Clock and write side
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read side
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
    s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  // Address and data offered together; released lines are inverted, not held
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~v};
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end while (!s_axi_rvalid);
    {v, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : tsgn_seq_model

// File: verif/tb_top.sv
// Self-checking bench for the task-switch gate block
`timescale 1ns/100ps
`include "tsgn_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  // Bus and decision signals
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        protection_fault, switch_taken;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [19:0] r;
  int          num_errors, n_checks;
  // Rows: request [15:0], target busy [16], fault [17], switched [18]
  localparam logic [19:0] ROWS [11] = '{20'h43008, 20'h22308, 20'h22D09, 20'h42A09,
    20'h23019, 20'h30000, 20'h40F02, 20'h30001, 20'h00003, 20'h50323, 20'h4030A};
  tsgn_ctrl i_dut (.*);
  tsgn_seq_model i_seq (.*);
  // 100 MHz clock
  initial forever #5 aclk = ~aclk;
  // Hang guard far beyond the few hundred cycles the run needs
  initial begin
    #50000 num_errors++;
    give_verdict();
  end
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Target descriptor goes in before the request word
  task automatic req(input logic [15:0] q, input logic b);
    i_seq.wr(`TSGN_OFF_DESC, 32'(b) << `TSGN_DESC_BUSY_BIT, resp);
    i_seq.wr(`TSGN_OFF_REQ, {16'hA5C3, q}, resp);
  endtask : req
  task automatic res(input logic [15:0] q, input logic b, input logic [31:0] m, e);
    req(q, b);
    i_seq.rd(`TSGN_OFF_RESULT, d, resp);
    `CHK(d & m, e)
  endtask : res
  // Reset held eight cycles; decisions must read clear after it
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({protection_fault, switch_taken}, 2'h0)
  endtask : do_reset
  // Table of requests, then the awkward cases and a reset in mid-run
  initial begin
    do_reset();
    for (int i = 0; i < 11; i++) begin
      r = ROWS[i];
      req(r[15:0], r[16]);
      `CHK(resp, `TSGN_RESP_OKAY)
      `CHK({switch_taken, protection_fault}, r[18:17])
      i_seq.rd(`TSGN_OFF_STATUS, d, resp);
      `CHK(d, {29'h0, r[18:17], 1'b1})
      i_seq.rd(`TSGN_OFF_DESC, d, resp);
      `CHK(d[9], r[16] | (r[18] & (r[1:0] != 2'h3)))
    end
    res(16'h0001, 1'b0, 32'hFFFFFFFF, 32'hA5C3001B);
    res(16'h0000, 1'b0, 32'h13, 32'h2);
    res(16'h0023, 1'b1, 32'h7, 32'h2);
    res(16'h0308, 1'b0, 32'hFFFFFFFF, 32'h1);
    i_seq.rd(8'h10, d, resp);
    `CHK(resp, `TSGN_RESP_SLVERR)
    // Clearing done keeps the last decision bits visible
    i_seq.wr(`TSGN_OFF_STATUS, 32'h0000_0001, resp);
    i_seq.rd(`TSGN_OFF_STATUS, d, resp);
    `CHK(d, 32'h0000_0002)
    // Unstrobed bytes land as zero; only byte one reaches the busy bit
    s_axi_wstrb <= 4'h2;
    i_seq.wr(`TSGN_OFF_DESC, 32'hFFFF_FFFF, resp);
    s_axi_wstrb <= 4'hF;
    i_seq.rd(`TSGN_OFF_DESC, d, resp);
    `CHK(d, 32'h0000_FF00)
    i_seq.wr(8'h10, 32'h0000_0001, resp);
    `CHK(resp, `TSGN_RESP_SLVERR)
    do_reset();
    i_seq.rd(`TSGN_OFF_STATUS, d, resp);
    `CHK(d, 32'h0000_0000)
    give_verdict();
  end
endmodule : tb_top
bind tsgn_ctrl tsgn_ctrl_sva i_sva (.*);
